// [rtl/sla_arbiter.sv]
// Operation
// - low eight counter bits readable as read-only data; reset clears them
// - any control register write clears the low eight counter bits
// - mode 00 resets counter and holds it idle
// - measure, clock select 0: bus/4 count, falling edge to next falling edge
// - running flag high while counting; done flag set on stop: second falling edge (select 0), receive rising edge (select 1)
// - measure, clock select 1: prescaler/4 count, starts on receive low
// - clock select 1: receive already low on enable starts counting at once
// - clock select 1 stops on next receive rising edge
// - mode 10 selects bus arbitration
// - arbitration restarts counter on each transmit rising edge
// - sample receive at count 38h (select 0) or 08h (select 1)
// - receive low at sample point sets arbitration lost flag
// - lost flag forces transmit pin high
// - transmit low before receive low resets counter until next rising edge
// - mode field: idle, measure, arbitration, reserved
// - lost flag cleared by writing zero to upper mode bit, and by reset; a loss detected in the same cycle as the write keeps it set
// - done, overflow and top bit cleared by any control write
// - overflow flag set when 9-bit counter overflows
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "sla_map.svh"

module sla_arbiter
  import sla_pkg::*;
#(
  parameter int CNT_W = 9
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial side
  input  wire logic        prescaler_tick,
  input  wire logic        rx_pin,
  input  wire logic        internal_transmit_signal,
  output logic             tx_pin,
  // interrupt
  output logic             irq
);

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic access_w;
  logic wr_ctl;
  logic wr_sts;
  logic wr_msk;
  logic addr_ok;

  assign access_w = psel && penable;
  assign wr_ctl   = access_w && pwrite && (paddr == `SLA_OFF_CONTROL) && pstrb[0];
  assign wr_sts   = access_w && pwrite && (paddr == `SLA_OFF_IRQ_STATUS) && pstrb[0];
  assign wr_msk   = access_w && pwrite && (paddr == `SLA_OFF_IRQ_MASK) && pstrb[0];
  assign addr_ok  = (paddr == `SLA_OFF_CONTROL) || (paddr == `SLA_OFF_COUNT_LOW) ||
                    (paddr == `SLA_OFF_IRQ_STATUS) || (paddr == `SLA_OFF_IRQ_MASK);
  assign pready   = 1'b1;
  assign pslverr  = access_w && !addr_ok;

  // --------------------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------------------
  logic [1:0] mode_q;
  logic       clk_sel_q;
  sla_mode_t  mode;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q    <= 2'h0;
      clk_sel_q <= 1'b0;
    end else if (wr_ctl) begin
      mode_q    <= {pwdata[`SLA_CTL_MODE_HI], pwdata[`SLA_CTL_MODE_LO]};
      clk_sel_q <= pwdata[`SLA_CTL_CLK_SEL];
    end
  end

  assign mode = sla_mode_t'(mode_q);

  logic idle_mode;
  logic meas_mode;
  logic arb_mode;

  assign idle_mode = (mode == SLA_MODE_IDLE) || (mode == SLA_MODE_RSVD);
  assign meas_mode = (mode == SLA_MODE_MEASURE);
  assign arb_mode  = (mode == SLA_MODE_ARB);

  // --------------------------------------------------------------------------
  // counter time base
  // --------------------------------------------------------------------------
  logic bus_tick;
  logic pre_tick;
  logic cnt_tick;
  logic div_clr;

  assign div_clr = idle_mode || wr_ctl;

  sla_tick_div #(
    .DIV (`SLA_BUS_DIV)
  ) u_bus_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clr      (div_clr),
    .in_tick  (1'b1),
    .out_tick (bus_tick)
  );

  sla_tick_div #(
    .DIV (`SLA_PRE_DIV)
  ) u_pre_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clr      (div_clr),
    .in_tick  (prescaler_tick),
    .out_tick (pre_tick)
  );

  assign cnt_tick = clk_sel_q ? pre_tick : bus_tick;

  // --------------------------------------------------------------------------
  // edge detection
  // --------------------------------------------------------------------------
  logic rx_q;
  logic txi_q;
  logic rx_fall;
  logic rx_rise;
  logic txi_rise;
  logic txi_fall;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_q  <= 1'b1;
      txi_q <= 1'b1;
    end else begin
      rx_q  <= rx_pin;
      txi_q <= internal_transmit_signal;
    end
  end

  assign rx_fall  = rx_q && !rx_pin;
  assign rx_rise  = !rx_q && rx_pin;
  assign txi_rise = !txi_q && internal_transmit_signal;
  assign txi_fall = txi_q && !internal_transmit_signal;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  sla_state_t  state_q;
  sla_state_t  state_d;
  logic        start;
  logic        stop;
  logic        restart;
  logic        abort;
  logic [CNT_W-1:0] cnt_q;
  logic        sample_pt;
  logic        rx_seen_low_q;

  assign sample_pt = (state_q == SLA_ST_COUNT) && cnt_tick &&
                     (cnt_q == (clk_sel_q ? `SLA_SAMPLE_PRE : `SLA_SAMPLE_BUS));

  always_comb begin
    state_d = state_q;
    start   = 1'b0;
    stop    = 1'b0;
    restart = 1'b0;
    abort   = 1'b0;
    case (state_q)
      SLA_ST_IDLE: begin
        if (meas_mode && !clk_sel_q) begin
          state_d = SLA_ST_ARMED;
        end else if (meas_mode && clk_sel_q) begin
          state_d = SLA_ST_ARMED;
        end else if (arb_mode) begin
          state_d = SLA_ST_ARMED;
        end
      end
      SLA_ST_ARMED: begin
        if (meas_mode && !clk_sel_q && rx_fall) begin
          start = 1'b1;
        end else if (meas_mode && clk_sel_q && !rx_pin) begin
          start = 1'b1;
        end else if (arb_mode && txi_rise) begin
          start = 1'b1;
        end
        if (start) begin
          state_d = SLA_ST_COUNT;
        end
      end
      SLA_ST_COUNT: begin
        if (meas_mode && !clk_sel_q && rx_fall) begin
          stop = 1'b1;
        end else if (meas_mode && clk_sel_q && rx_rise) begin
          stop = 1'b1;
        end else if (arb_mode && txi_rise) begin
          restart = 1'b1;
        end else if (arb_mode && txi_fall && !rx_seen_low_q) begin
          abort = 1'b1;
        end else if (arb_mode && sample_pt) begin
          state_d = SLA_ST_ARMED;
        end
        if (stop) begin
          state_d = SLA_ST_STOPPED;
        end else if (abort) begin
          state_d = SLA_ST_ARMED;
        end
      end
      SLA_ST_STOPPED: begin
        state_d = SLA_ST_STOPPED;
      end
      default: begin
        state_d = SLA_ST_IDLE;
      end
    endcase
    if (idle_mode || wr_ctl) begin
      state_d = SLA_ST_IDLE;
      start   = 1'b0;
      stop    = 1'b0;
      restart = 1'b0;
      abort   = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SLA_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // receive low seen since the last transmit rising edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_seen_low_q <= 1'b0;
    end else if (start || restart || state_q != SLA_ST_COUNT) begin
      rx_seen_low_q <= 1'b0;
    end else if (!rx_pin) begin
      rx_seen_low_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // counter and overflow
  // --------------------------------------------------------------------------
  logic ovf_q;
  logic ovf_evt;
  logic counting;

  assign counting = (state_q == SLA_ST_COUNT) && !stop && !abort && !restart;
  assign ovf_evt  = counting && cnt_tick && (cnt_q == {CNT_W{1'b1}}) && !wr_ctl;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (wr_ctl || idle_mode) begin
      cnt_q <= '0;
    end else if (start || restart || abort) begin
      cnt_q <= '0;
    end else if (counting && cnt_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_q <= 1'b0;
    end else if (ovf_evt) begin
      ovf_q <= 1'b1;
    end else if (wr_ctl) begin
      ovf_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // flags
  // --------------------------------------------------------------------------
  logic done_q;
  logic lost_q;
  logic lost_evt;
  logic done_evt;

  assign done_evt = stop;
  assign lost_evt = arb_mode && sample_pt && !rx_pin;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else if (wr_ctl) begin
      done_q <= 1'b0;
    end else if (done_evt) begin
      done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lost_q <= 1'b0;
    end else if (lost_evt) begin
      lost_q <= 1'b1;
    end else if (wr_ctl && !pwdata[`SLA_CTL_MODE_HI]) begin
      lost_q <= 1'b0;
    end
  end

  assign tx_pin = lost_q ? 1'b1 : internal_transmit_signal;

  // --------------------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------------------
  logic [`SLA_IRQ_W-1:0] irq_sts_q;
  logic [`SLA_IRQ_W-1:0] irq_msk_q;
  logic [`SLA_IRQ_W-1:0] irq_evt;

  assign irq_evt = {ovf_evt, lost_evt, done_evt};

  genvar gi;
  generate
    for (gi = 0; gi < `SLA_IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          irq_sts_q[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_sts_q[gi] <= 1'b1;
        end else if (wr_sts && pwdata[gi]) begin
          irq_sts_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_msk_q <= '0;
    end else if (wr_msk) begin
      irq_msk_q <= pwdata[`SLA_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_sts_q & irq_msk_q);

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  logic [7:0] ctl_rd;

  always_comb begin
    ctl_rd                     = `SLA_CTL_RESET;
    ctl_rd[`SLA_CTL_MODE_LO]   = mode_q[0];
    ctl_rd[`SLA_CTL_MODE_HI]   = mode_q[1];
    ctl_rd[`SLA_CTL_CLK_SEL]   = clk_sel_q;
    ctl_rd[`SLA_CTL_TOP_BIT]   = cnt_q[CNT_W-1];
    ctl_rd[`SLA_CTL_OVERFLOW]  = ovf_q;
    ctl_rd[`SLA_CTL_RUNNING]   = (state_q == SLA_ST_COUNT);
    ctl_rd[`SLA_CTL_DONE]      = done_q;
    ctl_rd[`SLA_CTL_LOST]      = lost_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SLA_OFF_CONTROL:    prdata <= {24'h00_0000, ctl_rd};
        `SLA_OFF_COUNT_LOW:  prdata <= {24'h00_0000, cnt_q[7:0]};
        `SLA_OFF_IRQ_STATUS: prdata <= {29'h0000_0000, irq_sts_q};
        `SLA_OFF_IRQ_MASK:   prdata <= {29'h0000_0000, irq_msk_q};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // sla_arbiter

// [rtl/sla_map.svh]
`ifndef SLA_MAP_SVH
`define SLA_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SLA_OFF_CONTROL    12'h000
`define SLA_OFF_COUNT_LOW  12'h004
`define SLA_OFF_IRQ_STATUS 12'h008
`define SLA_OFF_IRQ_MASK   12'h00C

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define SLA_CTL_MODE_LO    0
`define SLA_CTL_MODE_HI    1
`define SLA_CTL_CLK_SEL    2
`define SLA_CTL_TOP_BIT    3
`define SLA_CTL_OVERFLOW   4
`define SLA_CTL_RUNNING    5
`define SLA_CTL_DONE       6
`define SLA_CTL_LOST       7

// ----------------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------------
`define SLA_IRQ_DONE       0
`define SLA_IRQ_LOST       1
`define SLA_IRQ_OVERFLOW   2
`define SLA_IRQ_W          3

// ----------------------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------------------
`define SLA_BUS_DIV        4
`define SLA_PRE_DIV        4
`define SLA_SAMPLE_BUS     9'h038
`define SLA_SAMPLE_PRE     9'h008
`define SLA_CTL_RESET      8'h00

`endif

// [rtl/sla_pkg.sv]
package sla_pkg;

  typedef enum logic [1:0] {
    SLA_MODE_IDLE    = 2'b00,
    SLA_MODE_MEASURE = 2'b01,
    SLA_MODE_ARB     = 2'b10,
    SLA_MODE_RSVD    = 2'b11
  } sla_mode_t;

  typedef enum logic [1:0] {
    SLA_ST_IDLE,
    SLA_ST_ARMED,
    SLA_ST_COUNT,
    SLA_ST_STOPPED
  } sla_state_t;

endpackage

// [rtl/sla_tick_div.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// free-running divider: one-cycle tick every DIV qualified input ticks
// ----------------------------------------------------------------------------
module sla_tick_div #(
  parameter int DIV = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic clr,
  input  wire logic in_tick,
  // output
  output logic      out_tick
);

  localparam int W = $clog2(DIV) + 1;

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (in_tick) begin
      if (cnt_q == W'(DIV - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign out_tick = in_tick && (cnt_q == W'(DIV - 1));

endmodule // sla_tick_div

// [tb/serial_line_arbiter_counter_test.sv]
`timescale 1ns/100ps
`include "sla_map.svh"

module serial_line_arbiter_counter_test;
  localparam logic [11:0] A_CTL = `SLA_OFF_CONTROL;
  localparam logic [11:0] A_CNT = `SLA_OFF_COUNT_LOW;
  localparam logic [11:0] A_STS = `SLA_OFF_IRQ_STATUS;
  localparam logic [11:0] A_MSK = `SLA_OFF_IRQ_MASK;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        pre_tick = 0;
  logic        its = 1;
  logic        remote_low = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready;
  logic        pslverr;
  logic        rx;
  logic        tx;
  logic        irq;
  logic        e;
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;

  sla_arbiter DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prescaler_tick(pre_tick), .rx_pin(rx),
    .internal_transmit_signal(its), .tx_pin(tx), .irq(irq));
  sla_bus_node u_node (.tx_pin(tx), .remote_low(remote_low), .rx_pin(rx));

  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    pre_tick <= ~pre_tick;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rd(input logic [11:0] a);
    apb(0, a, 32'h0);
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, x, g);
    end
  endtask

  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    rd(A_CNT);
    chk("count", 32'h0, q);
    apb(1, A_CTL, 32'h1);
    repeat (2) @(posedge clk);
    remote_low <= 1;
    repeat (100) @(posedge clk);
    remote_low <= 0;
    repeat (100) @(posedge clk);
    remote_low <= 1;
    repeat (2) @(posedge clk);
    rd(A_CTL);
    chk("done run", 32'h2, {30'h0, q[6:5]});
    rd(A_CNT);
    chk("bus count", 32'h1, {31'h0, q > 48 && q < 52});
    apb(1, A_CTL, 32'h1);
    rd(A_CNT);
    chk("cleared", 32'h0, q);
    rd(A_CTL);
    chk("done clr", 32'h0, {31'h0, q[6]});
    remote_low <= 0;
    repeat (2) @(posedge clk);
    remote_low <= 1;
    repeat (100) @(posedge clk);
    rd(A_CTL);
    chk("running", 32'h1, {31'h0, q[5]});
    repeat (2100) @(posedge clk);
    rd(A_CTL);
    chk("ovf", 32'h1, {31'h0, q[4]});
    rd(A_STS);
    chk("ovf sts", 32'h1, {31'h0, q[2]});
    apb(1, A_MSK, 32'h4);
    @(negedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1, A_STS, 32'h7);
    @(negedge clk);
    chk("irq clr", 32'h0, {31'h0, irq});
    apb(1, A_MSK, 32'h0);
    apb(1, A_CTL, 32'h5);
    repeat (160) @(posedge clk);
    remote_low <= 0;
    repeat (50) @(posedge clk);
    rd(A_CNT);
    chk("break", 32'h1, {31'h0, q > 17 && q < 23});
    apb(1, A_CTL, 32'h0);
    repeat (20) @(posedge clk);
    rd(A_CNT);
    chk("idle", 32'h0, q);
    apb(1, A_CTL, 32'h3);
    remote_low <= 1;
    repeat (50) @(posedge clk);
    remote_low <= 0;
    rd(A_CNT);
    chk("rsvd", 32'h0, q);
    chk("rsvd tx", 32'h1, {31'h0, tx});
    its <= 0;
    apb(1, A_CTL, 32'h2);
    repeat (2) @(posedge clk);
    its <= 1;
    remote_low <= 1;
    repeat (260) @(posedge clk);
    its <= 0;
    repeat (2) @(posedge clk);
    chk("tx forced", 32'h1, {31'h0, tx});
    rd(A_CTL);
    chk("lost", 32'h1, {31'h0, q[7]});
    remote_low <= 0;
    apb(1, A_CTL, 32'h0);
    @(negedge clk);
    chk("tx free", 32'h0, {31'h0, tx});
    apb(1, A_CTL, 32'h2);
    repeat (2) @(posedge clk);
    its <= 1;
    repeat (100) @(posedge clk);
    its <= 0;
    repeat (300) @(posedge clk);
    rd(A_CTL);
    chk("no lost", 32'h0, {31'h0, q[7]});
    rd(A_CNT);
    chk("arb reset", 32'h0, q);
    apb(1, A_CTL, 32'h6);
    repeat (2) @(posedge clk);
    its <= 1;
    remote_low <= 1;
    repeat (90) @(posedge clk);
    rd(A_CTL);
    chk("lost pre", 32'h1, {31'h0, q[7]});
    remote_low <= 0;
    apb(1, A_CTL, 32'h0);
    rd(12'h010);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, q);
    summarize();
  end
endmodule // serial_line_arbiter_counter_test

// [tb/sla_arbiter_props.sv]
`timescale 1ns/100ps
`include "sla_map.svh"

module sla_arbiter_props #(
  parameter int CNT_W = 9
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial side
  input wire logic        rx_pin,
  input wire logic        internal_transmit_signal,
  input wire logic        tx_pin,
  input wire logic        irq
);
  logic       acc;
  logic       rd;
  logic       wr_ctl;
  logic [2:0] ctl_q;
  logic [2:0] mask_q;
  logic       idle_q;

  assign acc = psel & penable;
  assign rd = acc & ~pwrite;
  assign wr_ctl = acc & pwrite & pstrb[0] & (paddr == `SLA_OFF_CONTROL);

  // ----------------------------------------------------------------------------
  // shadows of what software wrote
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= 3'h0;
      idle_q <= 1'b1;
    end else if (wr_ctl) begin
      ctl_q <= pwdata[2:0];
      idle_q <= pwdata[1] == pwdata[0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= 3'h0;
    end else if (acc && pwrite && pstrb[0] && paddr == `SLA_OFF_IRQ_MASK) begin
      mask_q <= pwdata[2:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  zero_wait_a: assert property (acc |-> pready)
    else $error("access phase not ready");
  unmapped_err_a: assert property (rd && paddr > 12'h00C |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  ctl_readback_a: assert property (
    rd && paddr == `SLA_OFF_CONTROL |-> prdata[2:0] == ctl_q && prdata[31:8] == 24'h0)
    else $error("control readback wrong");
  count_width_a: assert property (
    rd && paddr == `SLA_OFF_COUNT_LOW |-> prdata[31:8] == 24'h0)
    else $error("count upper bits set");
  idle_count_a: assert property (
    idle_q && rd && paddr == `SLA_OFF_COUNT_LOW |-> prdata[7:0] == 8'h0)
    else $error("count not held in idle");
  mask_quiet_a: assert property (mask_q == 3'h0 |-> !irq)
    else $error("irq with all masked");
  lost_holds_a: assert property (
    tx_pin && !internal_transmit_signal && !wr_ctl |=> tx_pin)
    else $error("forced transmit released");
  lost_clear_a: assert property (
    wr_ctl && !pwdata[1] && rx_pin && $past(rx_pin) |=> tx_pin == internal_transmit_signal)
    else $error("lost not cleared");
endmodule // sla_arbiter_props

bind sla_arbiter sla_arbiter_props #(.CNT_W(CNT_W)) u_props (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_pin(rx_pin), .internal_transmit_signal(internal_transmit_signal),
  .tx_pin(tx_pin), .irq(irq));

// [tb/sla_bus_node.sv]
`timescale 1ns/100ps

module sla_bus_node (
  // shared line
  input  wire logic tx_pin,
  input  wire logic remote_low,
  output logic      rx_pin
);
  // pulled-up wired-and line: a dominant low from any node wins
  assign rx_pin = tx_pin & ~remote_low;
endmodule // sla_bus_node
